// ===== design/cps_blank_cnt.sv
// Blanking filter with 4-bit event counter and lockout
`timescale 1ns/10ps
`include "cps_consts.svh"
module cps_blank_cnt #(
  parameter int unsigned BLANK_CYC_P = `CPS_BLANK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic cond,
  output logic trip,
  output logic evt,
  output logic [3:0] count,
  output logic lock
);
  import cps_pkg::*;
  localparam logic [15:0] BLANK_CYC = 16'(BLANK_CYC_P);
  logic [15:0] timer_q;

  // ----------------------------------------
  // Blanking timer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_q <= 16'h0000;
    else if (!cond)
      timer_q <= 16'h0000;
    else if (timer_q != BLANK_CYC)
      timer_q <= timer_q + 16'h0001;
  end

  assign evt = cond && (timer_q == BLANK_CYC - 16'h0001);
  assign trip = cond && (timer_q == BLANK_CYC);

  // ----------------------------------------
  // Event counter
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 4'h0;
      lock <= 1'b0;
    end
    else if (clear)
    begin
      count <= 4'h0;
      lock <= 1'b0;
    end
    else if (evt && !lock)
    begin
      if (count == `CPS_CNT_LAST)
        lock <= 1'b1;
      else
        count <= count + 4'h1;
    end
  end

  property p_evt_held;
    @(posedge ref_clk) disable iff (!rst_n)
    evt |-> cond && $past(cond, 1);
  endproperty
  a_evt_held: assert property (p_evt_held) else $error("event without persisting condition");

  property p_drop_discard;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(cond) |=> timer_q == 16'h0000 && !trip;
  endproperty
  a_drop_discard: assert property (p_drop_discard) else $error("dropped condition kept");
endmodule : cps_blank_cnt

// ===== design/cps_ramp.sv
// Soft-start ramp of the pass switch drive
`timescale 1ns/10ps
`include "cps_consts.svh"
module cps_ramp (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic [7:0] level,
  output logic done
);
  import cps_pkg::*;
  localparam logic [7:0] STEP_LAST = 8'(`CPS_SS_STEP_CYC - 1);
  logic [7:0] div_q;
  logic step;

  // ----------------------------------------
  // Step divider and ramp
  // ----------------------------------------
  assign step = run && (div_q == STEP_LAST);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 8'h00;
    else if (!run || step)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 8'h00;
    else if (!run)
      level <= 8'h00;
    else if (step && level != `CPS_RAMP_FULL)
      level <= level + 8'h01;
  end

  assign done = run && (level == `CPS_RAMP_FULL);
endmodule : cps_ramp

// ===== design/cps_seq.sv
// Top of the charge protection sequencer
`timescale 1ns/10ps
`include "cps_consts.svh"
module cps_seq #(
  parameter int unsigned POR_DELAY_CYC = `CPS_POR_DELAY_CYC,
  parameter int unsigned BLANK_CYC_P = `CPS_BLANK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic supply_por_ok,
  input wire logic enable_n,
  input wire cps_pkg::cps_cond_s cond,
  input wire cps_pkg::cps_bus_s bus,
  output logic [31:0] rdata,
  output logic irq,
  output logic pass_on,
  output logic [7:0] drive_level,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic [3:0] bat_ovp_count,
  output logic [3:0] over_cur_count,
  output logic lockout
);
  import cps_pkg::*;

  localparam logic [19:0] DELAY_LAST = 20'(POR_DELAY_CYC - 1);

  cps_state_e state_q;
  cps_state_e state_d;
  logic [19:0] delay_q;
  logic ot_hold_q;
  logic por_clr;
  logic ocp_clr;
  logic bat_trip;
  logic bat_evt;
  logic bat_lock;
  logic cur_trip;
  logic cur_evt;
  logic cur_lock;
  logic ramp_run;
  logic ramp_done;
  logic [7:0] ramp_level;
  logic stop;
  logic ok_start;
  logic fault_any;
  logic lock_any;
  logic [4:0] status_q;
  logic [4:0] mask_q;
  logic [4:0] ev_set;
  logic in_ovp_q;
  logic ot_prev_q;
  logic lock_prev_q;

  // ----------------------------------------
  // Protection filters
  // ----------------------------------------
  assign por_clr = (state_q == CPS_POR) || (state_q == CPS_DELAY);
  assign ocp_clr = por_clr || enable_n;

  cps_blank_cnt #(.BLANK_CYC_P(BLANK_CYC_P)) u_bat (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(por_clr),
    .cond(cond.bat_ovp),
    .trip(bat_trip),
    .evt(bat_evt),
    .count(bat_ovp_count),
    .lock(bat_lock)
  );

  cps_blank_cnt #(.BLANK_CYC_P(BLANK_CYC_P)) u_cur (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(ocp_clr),
    .cond(cond.over_cur),
    .trip(cur_trip),
    .evt(cur_evt),
    .count(over_cur_count),
    .lock(cur_lock)
  );

  // ----------------------------------------
  // Over-temperature hysteresis
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ot_hold_q <= 1'b0;
    else if (cond.temp_hot)
      ot_hold_q <= 1'b1;
    else if (cond.temp_cool)
      ot_hold_q <= 1'b0;
  end

  // ----------------------------------------
  // Power-up delay timer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      delay_q <= 20'h00000;
    else if (state_q != CPS_DELAY)
      delay_q <= 20'h00000;
    else if (delay_q != DELAY_LAST)
      delay_q <= delay_q + 20'h00001;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign lock_any = bat_lock || cur_lock;
  assign stop = enable_n || cond.in_ovp || bat_trip || cur_trip || cond.temp_hot
    || ot_hold_q || lock_any;
  assign ok_start = !enable_n && !cond.in_ovp && !cond.bat_ovp && !cond.over_cur
    && !cond.temp_hot && !ot_hold_q && !lock_any;

  always_comb
  begin
    state_d = state_q;
    if (!supply_por_ok)
      state_d = CPS_POR;
    else
    begin
      unique case (state_q)
        CPS_POR:
          state_d = CPS_DELAY;
        CPS_DELAY:
          if (delay_q == DELAY_LAST)
            state_d = CPS_WAIT;
        CPS_WAIT:
          if (ok_start)
            state_d = CPS_SOFT;
        CPS_SOFT:
          if (stop)
            state_d = CPS_WAIT;
          else if (ramp_done)
            state_d = CPS_ON;
        CPS_ON:
          if (stop)
            state_d = CPS_WAIT;
        default:
          state_d = CPS_POR;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= CPS_POR;
    else
      state_q <= state_d;
  end

  assign ramp_run = (state_q == CPS_SOFT) || (state_q == CPS_ON);

  cps_ramp u_ramp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(ramp_run),
    .level(ramp_level),
    .done(ramp_done)
  );

  // ----------------------------------------
  // Switch drive
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pass_on <= 1'b0;
      drive_level <= 8'h00;
    end
    else if (state_d == CPS_SOFT || state_d == CPS_ON)
    begin
      pass_on <= 1'b1;
      drive_level <= ramp_level;
    end
    else
    begin
      pass_on <= 1'b0;
      drive_level <= 8'h00;
    end
  end

  // ----------------------------------------
  // Fault output
  // ----------------------------------------
  assign fault_any = cond.in_ovp || bat_trip || cur_trip || ot_hold_q || lock_any;
  assign fault_n_o = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_n_oe <= 1'b0;
      lockout <= 1'b0;
    end
    else
    begin
      fault_n_oe <= fault_any;
      lockout <= lock_any;
    end
  end

  // ----------------------------------------
  // Event flags and interrupt
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_ovp_q <= 1'b0;
      ot_prev_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end
    else
    begin
      in_ovp_q <= cond.in_ovp;
      ot_prev_q <= ot_hold_q;
      lock_prev_q <= lock_any;
    end
  end

  always_comb
  begin
    ev_set = 5'h00;
    ev_set[`CPS_ST_IN_OVP] = cond.in_ovp && !in_ovp_q;
    ev_set[`CPS_ST_BAT_OVP] = bat_evt;
    ev_set[`CPS_ST_OVER_CUR] = cur_evt;
    ev_set[`CPS_ST_OVER_TEMP] = ot_hold_q && !ot_prev_q;
    ev_set[`CPS_ST_LOCK] = lock_any && !lock_prev_q;
  end

  // Set wins over the clear of a status read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= 5'h00;
    else if (bus.rd_stb && bus.addr == `CPS_ADDR_STATUS)
      status_q <= ev_set;
    else
      status_q <= status_q | ev_set;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= `CPS_MASK_RST;
    else if (bus.wr_stb && bus.addr == `CPS_ADDR_MASK)
      mask_q <= bus.wdata[4:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (bus.rd_stb)
    begin
      unique case (bus.addr)
        `CPS_ADDR_STATUS:
          rdata <= {27'h0000000, status_q};
        `CPS_ADDR_MASK:
          rdata <= {27'h0000000, mask_q};
        `CPS_ADDR_INFO:
          rdata <= {16'h0000, drive_level, bat_ovp_count, over_cur_count} | {
            13'h0000, state_q, 16'h0000};
        default:
          rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_por_off;
    @(posedge ref_clk) disable iff (!rst_n)
    !supply_por_ok |=> !pass_on;
  endproperty
  a_por_off: assert property (p_por_off) else $error("switch on below reset level");

  property p_delay_off;
    @(posedge ref_clk) disable iff (!rst_n)
    state_q == CPS_DELAY |-> !pass_on;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("switch on during delay");

  property p_ovp_fast;
    @(posedge ref_clk) disable iff (!rst_n)
    cond.in_ovp |=> !pass_on && drive_level == 8'h00;
  endproperty
  a_ovp_fast: assert property (p_ovp_fast) else $error("overvoltage not removed");

  property p_start_clean;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(pass_on) |-> !$past(cond.in_ovp) && $past(state_q) == CPS_WAIT;
  endproperty
  a_start_clean: assert property (p_start_clean) else $error("bad soft-start entry");

  property p_lock_off;
    @(posedge ref_clk) disable iff (!rst_n)
    lock_any |=> !pass_on;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("switch on while locked");

  property p_por_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    !supply_por_ok ##1 !supply_por_ok |=> bat_ovp_count == 4'h0 && !bat_lock;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("counter kept over reset");

  property p_enable_off;
    @(posedge ref_clk) disable iff (!rst_n)
    enable_n |=> !pass_on ##1 !cur_lock;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("enable did not force off");

  property p_temp_off;
    @(posedge ref_clk) disable iff (!rst_n)
    cond.temp_hot ##1 !cond.temp_cool |-> !pass_on;
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("switch on while hot");

  property p_fault_pin;
    @(posedge ref_clk) disable iff (!rst_n)
    (cond.in_ovp || cur_trip) |=> fault_n_oe;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled");

  property p_trip_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (bat_trip || cur_trip) |=> !pass_on;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("blanked trip ignored");

  c_powerup: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == CPS_SOFT ##1 state_q == CPS_ON);
  c_retry: cover property (@(posedge ref_clk) disable iff (!rst_n)
    bat_evt ##[1:1000] $rose(pass_on));
  c_lockout: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(lock_any));
endmodule : cps_seq

// ===== include/cps_consts.svh
// Constants of the charge protection sequencer
// What this block does
// - The pass switch stays off while the supply has not risen past the power-on reset level.
// - About 10 ms after the supply passes that level the block resets itself and soft-starts.
// - Input overvoltage removes switch drive within 1 us, with no blanking.
// - When input overvoltage clears, the output comes back through a fresh soft-start.
// - Soft-start only begins with no input overvoltage, so an early one keeps the switch off.
// - Battery overvoltage must persist through a 180 us blanking time before the switch opens.
// - Confirmed battery overvoltage events are counted in 4 bits; the sixteenth locks off.
// - A fresh power-on reset clears the battery counter and restarts power-up.
// - Overcurrent must persist for 180 us before the switch opens.
// - Overcurrent events have their own 4-bit count; sixteen latch off until reset or enable.
// - Over-temperature at 150 C opens the switch until the die cools below 110 C.
// - The open-drain fault output pulls low while any protection event is active.
// - The enable input is active low; high forces the pass switch off.
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
`define CPS_CLK_MHZ 100
`define CPS_POR_DELAY_MS 10
`define CPS_POR_DELAY_CYC (`CPS_POR_DELAY_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_BLANK_US 180
`define CPS_BLANK_CYC (`CPS_BLANK_US * `CPS_CLK_MHZ)
`define CPS_OVP_RESP_US 1
`define CPS_OVP_RESP_CYC (`CPS_OVP_RESP_US * `CPS_CLK_MHZ)
`define CPS_SS_STEP_CYC 40
`define CPS_RAMP_FULL 8'hff
`define CPS_CNT_LAST 4'hf
`define CPS_ADDR_STATUS 4'h0
`define CPS_ADDR_MASK 4'h4
`define CPS_ADDR_INFO 4'h8
`define CPS_ST_IN_OVP 0
`define CPS_ST_BAT_OVP 1
`define CPS_ST_OVER_CUR 2
`define CPS_ST_OVER_TEMP 3
`define CPS_ST_LOCK 4
`define CPS_MASK_RST 5'h00
`endif

// ===== include/cps_pkg.sv
// Types of the charge protection sequencer
package cps_pkg;
  typedef enum logic [2:0] {
    CPS_POR = 3'b000,
    CPS_DELAY = 3'b001,
    CPS_WAIT = 3'b010,
    CPS_SOFT = 3'b011,
    CPS_ON = 3'b100
  } cps_state_e;

  typedef struct packed {
    logic in_ovp;
    logic bat_ovp;
    logic over_cur;
    logic temp_hot;
    logic temp_cool;
  } cps_cond_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } cps_bus_s;
endpackage : cps_pkg

// ===== tb/cps_far_model.sv
// Far-side model: adapter and charger conditions, enable driver, fault pull-up
`timescale 1ns/10ps
module cps_far_model (
  input wire cps_pkg::cps_cond_s want,
  input wire logic want_en,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  output cps_pkg::cps_cond_s cond,
  output logic enable_n,
  output logic fault_line
);
  import cps_pkg::*;
  // ----------------------------------------
  // Pins seen by the block
  // ----------------------------------------
  assign cond = want;
  assign enable_n = ~want_en;
  // Open-drain line with pull-up resistor
  assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
endmodule : cps_far_model

// ===== tb/tb_charge_protection_sequencer.sv
// Self-checking testbench of the charge protection sequencer
`timescale 1ns/10ps
`include "cps_consts.svh"
module tb_charge_protection_sequencer;
  import cps_pkg::*;
  localparam int unsigned POR_CYC = 50;
  localparam int unsigned BLANK = 400;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_por_ok = 1'b0;
  logic want_en = 1'b1;
  cps_cond_s want = '0;
  cps_cond_s cond;
  cps_bus_s bus = '0;
  logic enable_n, irq, pass_on, fault_n_o, fault_n_oe, lockout, fault_line;
  logic [31:0] rdata, d;
  logic [7:0] drive_level;
  logic [3:0] bat_ovp_count, over_cur_count;
  int n_fail = 0;
  int n_tests = 0;
  int i;

  cps_seq #(.POR_DELAY_CYC(POR_CYC), .BLANK_CYC_P(BLANK)) cps_seq_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .supply_por_ok(supply_por_ok), .enable_n(enable_n), .cond(cond), .bus(bus),
    .rdata(rdata), .irq(irq), .pass_on(pass_on), .drive_level(drive_level),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .bat_ovp_count(bat_ovp_count),
    .over_cur_count(over_cur_count), .lockout(lockout));
  cps_far_model cps_far_model_i (.want(want), .want_en(want_en), .fault_n_o(fault_n_o),
    .fault_n_oe(fault_n_oe), .cond(cond), .enable_n(enable_n), .fault_line(fault_line));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int ramp_cyc();
    return 255 * `CPS_SS_STEP_CYC;
  endfunction : ramp_cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : edges

  task automatic wait_pass(input logic v, input int lim);
    int k;
    k = 0;
    while (pass_on !== v && k < lim)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk(pass_on, v);
  endtask : wait_pass

  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    bus <= '{a, w, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '{a, w, 1'b0, 1'b0};
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    @(posedge ref_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus.rd_stb <= 1'b0;
    @(negedge ref_clk);
    r = rdata;
  endtask : rd

  // Holds one blanked condition (bit index of cond) for a given span
  task automatic hold_cond(input int b, input int n);
    @(posedge ref_clk);
    want[b] <= 1'b1;
    repeat (n) @(posedge ref_clk);
  endtask : hold_cond

  task automatic drop_cond(input int b);
    @(posedge ref_clk);
    want[b] <= 1'b0;
  endtask : drop_cond

  // Confirmed events of one blanked condition, each followed by a drop
  task automatic pulse_evts(input int b, input int n);
    repeat (n)
    begin
      hold_cond(b, BLANK + 5);
      drop_cond(b);
    end
  endtask : pulse_evts

  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #800000;
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h7b1f25f7));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    edges(100);
    chk(pass_on, 1'b0);
    chk(fault_line, 1'b1);
    rd(`CPS_ADDR_MASK, d);
    chk(d, 32'h0);
    rd(4'hc, d);
    chk(d, 32'h0);
    @(posedge ref_clk);
    supply_por_ok <= 1'b1;
    edges(POR_CYC - 5);
    chk(pass_on, 1'b0);
    wait_pass(1'b1, 20);
    i = 0;
    while (drive_level !== 8'hff && i < ramp_cyc() + 100)
    begin
      @(negedge ref_clk);
      i++;
    end
    chk(drive_level, 8'hff);
    rd(`CPS_ADDR_INFO, d);
    chk(d[18:16], 32'h4);
    // Input overvoltage, first masked then unmasked
    wr(`CPS_ADDR_MASK, 32'h0);
    @(posedge ref_clk);
    want.in_ovp <= 1'b1;
    edges(3);
    chk(pass_on, 1'b0);
    chk(fault_line, 1'b0);
    chk(irq, 1'b0);
    wr(`CPS_ADDR_MASK, 32'h1);
    edges(2);
    chk(irq, 1'b1);
    rd(`CPS_ADDR_STATUS, d);
    chk(d & 32'h1f, 32'h1);
    @(posedge ref_clk);
    want.in_ovp <= 1'b0;
    wait_pass(1'b1, 200);
    edges(2);
    chk(irq, 1'b0);
    // Short battery overvoltage glitch is discarded
    hold_cond(3, 20 + ($urandom % (BLANK - 40)));
    drop_cond(3);
    edges(5);
    chk(bat_ovp_count, 4'h0);
    chk(pass_on, 1'b1);
    // Confirmed battery overvoltage
    wr(`CPS_ADDR_MASK, 32'h2);
    hold_cond(3, BLANK - 100);
    edges(0);
    chk(pass_on, 1'b1);
    wait_pass(1'b0, 200);
    chk(bat_ovp_count, 4'h1);
    chk(fault_n_oe, 1'b1);
    edges(2);
    chk(irq, 1'b1);
    drop_cond(3);
    wait_pass(1'b1, 200);
    // Overcurrent short and long
    hold_cond(2, 50);
    drop_cond(2);
    edges(3);
    chk(over_cur_count, 4'h0);
    hold_cond(2, BLANK - 100);
    edges(0);
    chk(pass_on, 1'b1);
    wait_pass(1'b0, 200);
    chk(over_cur_count, 4'h1);
    drop_cond(2);
    wait_pass(1'b1, 200);
    // Enable toggle clears overcurrent count only
    @(posedge ref_clk);
    want_en <= 1'b0;
    edges(3);
    chk(pass_on, 1'b0);
    chk(over_cur_count, 4'h0);
    chk(bat_ovp_count, 4'h1);
    @(posedge ref_clk);
    want_en <= 1'b1;
    wait_pass(1'b1, 200);
    // Sixteen overcurrent events latch off until enable toggles
    pulse_evts(2, 16);
    edges(3);
    chk(lockout, 1'b1);
    chk(over_cur_count, 4'hf);
    chk(pass_on, 1'b0);
    @(posedge ref_clk);
    want_en <= 1'b0;
    edges(3);
    chk(lockout, 1'b0);
    @(posedge ref_clk);
    want_en <= 1'b1;
    wait_pass(1'b1, 200);
    // Over-temperature with hysteresis
    @(posedge ref_clk);
    want.temp_hot <= 1'b1;
    edges(3);
    chk(pass_on, 1'b0);
    @(posedge ref_clk);
    want.temp_hot <= 1'b0;
    edges(50);
    chk(pass_on, 1'b0);
    @(posedge ref_clk);
    want.temp_cool <= 1'b1;
    wait_pass(1'b1, 200);
    // Fifteen more battery events make sixteen: off until a power-on reset, enable cannot clear it
    pulse_evts(3, 15);
    edges(3);
    chk(lockout, 1'b1);
    chk(bat_ovp_count, 4'hf);
    @(posedge ref_clk);
    want_en <= 1'b0;
    edges(3);
    @(posedge ref_clk);
    want_en <= 1'b1;
    edges(100);
    chk(pass_on, 1'b0);
    chk(lockout, 1'b1);
    // Supply recycle, overvoltage present before the delay ends
    @(posedge ref_clk);
    want.temp_cool <= 1'b0;
    supply_por_ok <= 1'b0;
    edges(3);
    chk(pass_on, 1'b0);
    chk(bat_ovp_count, 4'h0);
    chk(lockout, 1'b0);
    @(posedge ref_clk);
    want.in_ovp <= 1'b1;
    supply_por_ok <= 1'b1;
    edges(POR_CYC + 150);
    chk(pass_on, 1'b0);
    @(posedge ref_clk);
    want.in_ovp <= 1'b0;
    wait_pass(1'b1, 200);
    chk(lockout, 1'b0);
    print_verdict();
  end
endmodule : tb_charge_protection_sequencer
